// ### tb/sbg_break_gen_test.sv
/* Bench for the break generator: Avalon-MM tasks and line timing.
   Assumes the design package and the line node model. */
`timescale 1ns/1ps
module sbg_break_gen_test;
  import sbg_pkg::*;
  localparam int BIT = 6;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        tx_pin;
  logic [31:0] low_len;
  logic [31:0] low_cnt;
  logic [31:0] rd;
  logic [31:0] c0;
  int          err_total = 0;
  int          comparisons = 0;
  always #50 core_clk = ~core_clk;
  sbg_break_gen u_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_pin(tx_pin));
  sbg_line_node u_node (.core_clk(core_clk), .tx_pin(tx_pin), .low_len(low_len), .low_cnt(low_cnt));
  task automatic complete_run;
    $display("Counts: %0d compared, %0d bad", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fail_wait;
    err_total++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) fail_wait();
    @(posedge core_clk);
  endtask
  // Waits for one whole low run, checks its length, then quiet line
  task automatic brk(input int bits);
    int n;
    n = 0;
    while (!(low_cnt != c0 && tx_pin === 1'b1) && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000) fail_wait();
    @(posedge core_clk);
    chk(low_len, bits * BIT);
    repeat (40 * BIT) @(posedge core_clk);
    chk(low_cnt, c0 + 1);
  endtask
  task automatic t_reset;
    chk({31'h0, tx_pin}, 32'h1);
    bus(1'b0, SBG_OFF_BAUD, 32'h0);
    chk(rd, {16'h0, SBG_BAUD_RST});
    bus(1'b0, SBG_OFF_STAT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, SBG_OFF_BAUD, 32'h5);
    bus(1'b0, SBG_OFF_BAUD, 32'h0);
    chk(rd, 32'h5);
    $display("reset test done");
  endtask
  task automatic t_lengths;
    logic [3:0] ctl [4] = '{4'h3, 4'h7, 4'hb, 4'hf};
    int         len [4] = '{10, 11, 13, 11};
    bus(1'b1, SBG_OFF_CTRL, 32'h2);
    repeat (12 * BIT) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      c0 = low_cnt;
      bus(1'b1, SBG_OFF_CTRL, {28'h0, ctl[i]});
      bus(1'b1, SBG_OFF_CTRL, {28'h0, ctl[i] & 4'he});
      brk(len[i]);
    end
    $display("length test done");
  endtask
  task automatic t_held;
    int lows;
    lows = 0;
    bus(1'b1, SBG_OFF_CTRL, 32'h3);
    repeat (40 * BIT) begin
      @(posedge core_clk);
      lows += (tx_pin === 1'b0);
    end
    bus(1'b1, SBG_OFF_CTRL, 32'h2);
    chk(lows >= 30 * BIT, 32'h1);
    repeat (30 * BIT) @(posedge core_clk);
    $display("held test done");
  endtask
  task automatic t_idle;
    realtime t0;
    bus(1'b1, SBG_OFF_CTRL, 32'h0);
    c0 = low_cnt;
    t0 = $realtime;
    bus(1'b1, SBG_OFF_CTRL, 32'h2);
    bus(1'b1, SBG_OFF_CTRL, 32'h3);
    bus(1'b1, SBG_OFF_CTRL, 32'h2);
    for (int n = 0; n < 2000 && low_cnt == c0; n++) @(posedge core_clk);
    chk(($realtime - t0) >= 10 * BIT * 100 && ($realtime - t0) <= 12 * BIT * 100, 32'h1);
    brk(10);
    $display("idle test done");
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_lengths();
    t_held();
    t_idle();
    complete_run();
  end
endmodule

// ### tb/sbg_line_node.sv
/* Line node: times each low run seen on tx_pin.
   Assumes the bench clock and an idle-high line. */
`timescale 1ns/1ps
module sbg_line_node (
  input  wire logic        core_clk,
  input  wire logic        tx_pin,
  output logic      [31:0] low_len,
  output logic      [31:0] low_cnt
);
  logic [31:0] run;
  initial begin
    run = '0;
    low_len = '0;
    low_cnt = '0;
  end
  // Low runs give break lengths; falling edges count breaks
  always @(posedge core_clk) begin
    run <= tx_pin ? 32'h0 : run + 32'h1;
    if (!tx_pin && run == 32'h0) low_cnt <= low_cnt + 32'h1;
    if (tx_pin && run != 32'h0) low_len <= run;
  end
endmodule

// ### verilog/sbg_break_gen.sv
/*
  Break and idle-line generator for an asynchronous transmitter with a
  LIN master mode, reached over Avalon-MM with waitrequest.
  Assumes one core clock; the baud tick is derived locally from the baud register.
*/
//
// Contract
// [R1] Setting then clearing the break request sends exactly one break.
// [R2] Normal mode break is 10 bits for word length 0, 11 for 1.
// [R3] While the break request stays set, breaks follow back to back.
// [R4] LIN master when LIN enable is 1 and word length is 0.
// [R5] LIN master break lasts exactly 13 bit times.
// [R6] Clearing then setting tx_on queues an idle before a later break.
// [R7] An idle ahead of a break occupies 10 bit times.
// [R8] Periods counted in whole baud ticks, starting on a bit boundary.
`timescale 1ns/1ps
module sbg_break_gen
  import sbg_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic [SBG_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [SBG_DATA_W-1:0] avs_writedata,
  output logic      [SBG_DATA_W-1:0] avs_readdata,
  output logic                       avs_waitrequest,
  output logic                       tx_pin
);
  sbg_state_r_t s_r, s_nxt;
  logic         lin_master;
  logic [3:0]   brk_len;

  assign lin_master = s_r.lin_en & ~s_r.wlen; // [R4]
  assign brk_len    = lin_master ? SBG_BITS_BRKLIN : // [R5]
                      (s_r.wlen ? SBG_BITS_BRK9 : SBG_BITS_BRK8); // [R2]

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    // Baud tick divider, free running so bits align to it
    if (s_r.div == '0) begin // [R8]
      s_nxt.div  = s_r.baud;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div - 16'h0001;
    end
    // Bus slave: one wait cycle per access
    s_nxt.wait_n = 1'b0;
    s_nxt.rdata  = '0;
    if ((avs_read | avs_write) & ~s_r.wait_n) begin
      s_nxt.wait_n = 1'b1;
      if (avs_read) begin
        unique case (avs_address)
          SBG_OFF_CTRL: begin
            s_nxt.rdata[SBG_CTRL_BRK]  = s_r.brk_req;
            s_nxt.rdata[SBG_CTRL_TXON] = s_r.tx_on;
            s_nxt.rdata[SBG_CTRL_WLEN] = s_r.wlen;
            s_nxt.rdata[SBG_CTRL_LIN]  = s_r.lin_en;
          end
          SBG_OFF_BAUD: s_nxt.rdata[SBG_BAUD_W-1:0] = s_r.baud;
          SBG_OFF_STAT: begin
            s_nxt.rdata[SBG_STAT_BUSY]  = s_r.st != SBG_ST_IDLE;
            s_nxt.rdata[SBG_STAT_BRK]   = s_r.st == SBG_ST_BREAK;
            s_nxt.rdata[SBG_STAT_IDLE]  = s_r.st == SBG_ST_IDLECH;
            s_nxt.rdata[SBG_STAT_IDLEQ] = s_r.idle_q;
            s_nxt.rdata[SBG_STAT_LINM]  = lin_master;
          end
          default: s_nxt.rdata = '0;
        endcase
      end else begin
        unique case (avs_address)
          SBG_OFF_CTRL: begin
            s_nxt.brk_req = avs_writedata[SBG_CTRL_BRK];
            s_nxt.tx_on   = avs_writedata[SBG_CTRL_TXON];
            s_nxt.wlen    = avs_writedata[SBG_CTRL_WLEN];
            s_nxt.lin_en  = avs_writedata[SBG_CTRL_LIN];
            if (avs_writedata[SBG_CTRL_BRK])
              s_nxt.brk_seen = 1'b1; // [R1]
            if (avs_writedata[SBG_CTRL_TXON] & ~s_r.tx_on)
              s_nxt.idle_q = 1'b1; // [R6]
          end
          SBG_OFF_BAUD: s_nxt.baud = avs_writedata[SBG_BAUD_W-1:0];
          default: ;
        endcase
      end
    end
    // Line sequencer, advances only on baud ticks
    if (s_r.tick) begin
      unique case (s_r.st)
        SBG_ST_IDLE: begin
          s_nxt.txd = 1'b1;
          if (s_r.tx_on & s_r.idle_q) begin
            s_nxt.st     = SBG_ST_IDLECH; // [R6]
            s_nxt.bits   = SBG_BITS_IDLE - 4'h1; // [R7]
            s_nxt.idle_q = 1'b0;
          end else if (s_r.tx_on & (s_r.brk_req | s_r.brk_seen)) begin
            s_nxt.st       = SBG_ST_BREAK; // [R1]
            s_nxt.bits     = brk_len - 4'h1; // [R2] [R5]
            s_nxt.txd      = 1'b0;
            s_nxt.brk_seen = 1'b0;
          end
        end
        SBG_ST_IDLECH: begin
          s_nxt.txd = 1'b1;
          // A pending break follows the idle with no extra bit time
          if (s_r.bits != '0) begin
            s_nxt.bits = s_r.bits - 4'h1; // [R8]
          end else if (s_r.tx_on & (s_r.brk_req | s_r.brk_seen)) begin
            s_nxt.st       = SBG_ST_BREAK; // [R6] [R7]
            s_nxt.bits     = brk_len - 4'h1; // [R2] [R5]
            s_nxt.txd      = 1'b0;
            s_nxt.brk_seen = 1'b0;
          end else begin
            s_nxt.st = SBG_ST_IDLE;
          end
        end
        SBG_ST_BREAK: begin
          if (s_r.bits != '0) begin
            s_nxt.bits = s_r.bits - 4'h1; // [R8]
            s_nxt.txd  = 1'b0;
          end else if (s_r.tx_on & s_r.brk_req) begin
            s_nxt.bits     = brk_len - 4'h1; // [R3]
            s_nxt.txd      = 1'b0;
            s_nxt.brk_seen = 1'b0;
          end else begin
            s_nxt.st  = SBG_ST_IDLE; // [R1]
            s_nxt.txd = 1'b1;
          end
        end
        default: s_nxt.st = SBG_ST_IDLE;
      endcase
    end
    // Set pulse seen in the same cycle as an end still counts
    if (avs_write & ~s_r.wait_n & (avs_address == SBG_OFF_CTRL) & avs_writedata[SBG_CTRL_BRK])
      s_nxt.brk_seen = 1'b1; // [R1]
    if (avs_write & ~s_r.wait_n & (avs_address == SBG_OFF_CTRL)
        & avs_writedata[SBG_CTRL_TXON] & ~s_r.tx_on)
      s_nxt.idle_q = 1'b1; // [R6]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r          <= '0;
      s_r.st       <= SBG_ST_IDLE;
      s_r.baud     <= SBG_BAUD_RST;
      s_r.txd      <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = ~s_r.wait_n;
  assign tx_pin          = s_r.txd;

  // Assertions
  logic [4:0] low_cnt_r;
  always_ff @(posedge core_clk) begin
    if (rst)
      low_cnt_r <= '0;
    else if (s_r.tick)
      low_cnt_r <= (s_r.txd | ((s_r.st == SBG_ST_BREAK) & (s_r.bits == '0))) ? 5'h00 : low_cnt_r + 5'h01;
  end

  // Low ticks are counted per break character, restarting at each reload
  property p_brk_len_bound;
    @(posedge core_clk) disable iff (rst) low_cnt_r <= 5'h0d;
  endproperty
  a_brk_len_bound: assert property (p_brk_len_bound) else $error("break too long"); // [R5]

  property p_lin_mode;
    @(posedge core_clk) disable iff (rst)
      (s_r.tick && s_r.st == SBG_ST_IDLE && s_nxt.st == SBG_ST_BREAK && lin_master) |=> s_r.bits == 4'hc;
  endproperty
  a_lin_mode: assert property (p_lin_mode) else $error("lin break length wrong"); // [R4]

  property p_norm_len;
    @(posedge core_clk) disable iff (rst)
      (s_r.tick && s_r.st == SBG_ST_IDLE && s_nxt.st == SBG_ST_BREAK && !lin_master)
        |=> s_r.bits == (s_r.wlen ? 4'ha : 4'h9);
  endproperty
  a_norm_len: assert property (p_norm_len) else $error("normal break length wrong"); // [R2]

  property p_break_low;
    @(posedge core_clk) disable iff (rst) (s_r.st == SBG_ST_BREAK && s_r.bits != '0) |-> !s_r.txd;
  endproperty
  a_break_low: assert property (p_break_low) else $error("line high inside break"); // [R1]

  property p_idle_high;
    @(posedge core_clk) disable iff (rst) (s_r.st == SBG_ST_IDLECH) |-> s_r.txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low during idle"); // [R7]

  property p_repeat;
    @(posedge core_clk) disable iff (rst)
      (s_r.tick && s_r.st == SBG_ST_BREAK && s_r.bits == '0 && s_r.tx_on && s_r.brk_req) |=> s_r.st == SBG_ST_BREAK;
  endproperty
  a_repeat: assert property (p_repeat) else $error("break did not repeat"); // [R3]

  property p_idle_queue;
    @(posedge core_clk) disable iff (rst)
      (s_r.tick && s_r.st == SBG_ST_IDLE && s_r.tx_on && s_r.idle_q) |=> s_r.st == SBG_ST_IDLECH && s_r.bits == 4'h9;
  endproperty
  a_idle_queue: assert property (p_idle_queue) else $error("queued idle not sent"); // [R6]

  property p_tick_step;
    @(posedge core_clk) disable iff (rst) (!s_r.tick) |=> $stable(s_r.st);
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("state moved off bit boundary"); // [R8]

  // Bus: a taken request is answered by one low waitrequest cycle
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_bus_answer;
    @(posedge core_clk) disable iff (rst) s_take |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

  // Bus: no request means waitrequest stays high
  property p_wait_quiet;
    @(posedge core_clk) disable iff (rst) !(avs_read || avs_write) |=> avs_waitrequest;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("waitrequest low without request");

  // Bus: read data is zero outside the answer cycle
  property p_rdata_quiet;
    @(posedge core_clk) disable iff (rst) avs_waitrequest |-> avs_readdata == '0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer");

  // Idle end with a break pending goes straight into the break
  sequence s_idle_done;
    s_r.tick && s_r.st == SBG_ST_IDLECH && s_r.bits == '0 && s_r.tx_on && (s_r.brk_req || s_r.brk_seen);
  endsequence

  property p_idle_to_break;
    @(posedge core_clk) disable iff (rst) s_idle_done |=> s_r.st == SBG_ST_BREAK && !s_r.txd;
  endproperty
  a_idle_to_break: assert property (p_idle_to_break) else $error("break late after idle"); // [R7]

  // Last bit of a break with no held request returns the line high
  property p_break_end;
    @(posedge core_clk) disable iff (rst)
      (s_r.tick && s_r.st == SBG_ST_BREAK && s_r.bits == '0 && !(s_r.tx_on && s_r.brk_req))
        |=> s_r.st == SBG_ST_IDLE && s_r.txd;
  endproperty
  a_break_end: assert property (p_break_end) else $error("break did not end"); // [R1]

  // Resting line is high
  property p_rest_high;
    @(posedge core_clk) disable iff (rst) s_r.st == SBG_ST_IDLE |-> s_r.txd;
  endproperty
  a_rest_high: assert property (p_rest_high) else $error("line low at rest"); // [R1]

  // A write that sets the break request is remembered
  property p_seen_set;
    @(posedge core_clk) disable iff (rst)
      (avs_write && avs_waitrequest && avs_address == SBG_OFF_CTRL && avs_writedata[SBG_CTRL_BRK])
        |=> s_r.brk_seen;
  endproperty
  a_seen_set: assert property (p_seen_set) else $error("break request lost"); // [R1]

  // A rising tx_on queues an idle line
  property p_queue_set;
    @(posedge core_clk) disable iff (rst)
      (avs_write && avs_waitrequest && avs_address == SBG_OFF_CTRL && avs_writedata[SBG_CTRL_TXON] && !s_r.tx_on)
        |=> s_r.idle_q;
  endproperty
  a_queue_set: assert property (p_queue_set) else $error("idle not queued"); // [R6]

  // Status read reports LIN master mode
  property p_stat_lin;
    @(posedge core_clk) disable iff (rst)
      (avs_read && avs_waitrequest && avs_address == SBG_OFF_STAT)
        |=> avs_readdata[SBG_STAT_LINM] == $past(lin_master);
  endproperty
  a_stat_lin: assert property (p_stat_lin) else $error("lin status wrong"); // [R4]
endmodule

// ### verilog/sbg_pkg.sv
/*
  Package for the serial break generator: field layouts, bit-time counts,
  register map and the packed state of the block.
  Assumes a single 10 MHz core clock and synchronous active-high reset.
*/
package sbg_pkg;
  localparam int          SBG_DATA_W      = 32;
  localparam int          SBG_ADDR_W      = 4;
  // Register byte offsets
  localparam logic [3:0]  SBG_OFF_CTRL    = 4'h0;
  localparam logic [3:0]  SBG_OFF_BAUD    = 4'h4;
  localparam logic [3:0]  SBG_OFF_STAT    = 4'h8;
  // Control fields
  localparam int          SBG_CTRL_BRK    = 0;
  localparam int          SBG_CTRL_TXON   = 1;
  localparam int          SBG_CTRL_WLEN   = 2;
  localparam int          SBG_CTRL_LIN    = 3;
  // Status fields
  localparam int          SBG_STAT_BUSY   = 0;
  localparam int          SBG_STAT_BRK    = 1;
  localparam int          SBG_STAT_IDLE   = 2;
  localparam int          SBG_STAT_IDLEQ  = 3;
  localparam int          SBG_STAT_LINM   = 4;
  // Bit-time lengths
  localparam logic [3:0]  SBG_BITS_BRK8   = 4'ha;
  localparam logic [3:0]  SBG_BITS_BRK9   = 4'hb;
  localparam logic [3:0]  SBG_BITS_BRKLIN = 4'hd;
  localparam logic [3:0]  SBG_BITS_IDLE   = 4'ha;
  localparam int          SBG_BAUD_W      = 16;
  localparam logic [15:0] SBG_BAUD_RST    = 16'h0004;

  typedef enum logic [1:0] {
    SBG_ST_IDLE = 2'b00,
    SBG_ST_IDLECH = 2'b01,
    SBG_ST_BREAK = 2'b10
  } sbg_state_t;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [3:0] address;
    logic [31:0] writedata;
  } sbg_bus_req_t;

  typedef struct packed {
    sbg_state_t  st;
    logic        brk_req;
    logic        brk_seen;
    logic        tx_on;
    logic        wlen;
    logic        lin_en;
    logic        idle_q;
    logic [15:0] baud;
    logic [15:0] div;
    logic [3:0]  bits;
    logic        tick;
    logic        txd;
    logic        wait_n;
    logic [31:0] rdata;
  } sbg_state_r_t;
endpackage
